// ### logic/cslr_pkg.sv
// Shared constants and types for the shift, logic and return slice of the 8-bit core.
// Assumes a byte-wide memory with an asynchronous read path, and an APB master.
package cslr_pkg;

	// ----------------------------------------
	// Opcode fields: high nibble is the mode
	// ----------------------------------------
	localparam logic [3:0] HI_RMW_DIR = 4'h3;
	localparam logic [3:0] HI_RMW_ACC = 4'h4;
	localparam logic [3:0] HI_RMW_IDX = 4'h5;
	localparam logic [3:0] HI_RMW_IX1 = 4'h6;
	localparam logic [3:0] HI_RMW_IX0 = 4'h7;
	localparam logic [3:0] HI_IMM = 4'hA;
	localparam logic [3:0] HI_DIR = 4'hB;
	localparam logic [3:0] HI_EXT = 4'hC;
	localparam logic [3:0] HI_IX2 = 4'hD;
	localparam logic [3:0] HI_IX1 = 4'hE;
	localparam logic [3:0] HI_IX0 = 4'hF;
	// Low nibble is the operation
	localparam logic [3:0] LO_NEG = 4'h0;
	localparam logic [3:0] LO_LSR = 4'h4;
	localparam logic [3:0] LO_ROR = 4'h6;
	localparam logic [3:0] LO_LSL = 4'h8;
	localparam logic [3:0] LO_ROL = 4'h9;
	localparam logic [3:0] LO_ORA = 4'hA;
	localparam logic [3:0] LO_LDX = 4'hE;
	// Whole-byte inherent opcodes
	localparam logic [7:0] OPC_RTI = 8'h80;
	localparam logic [7:0] OPC_MUL = 8'h42;
	localparam logic [7:0] OPC_RSP = 8'h9C;
	localparam logic [7:0] OPC_NOP = 8'h9D;

	// ----------------------------------------
	// Cycle counts per instruction
	// ----------------------------------------
	localparam logic [3:0] CYC_INH = 4'h2;
	localparam logic [3:0] CYC_MUL = 4'hB;
	localparam logic [3:0] CYC_RTI = 4'h9;
	localparam logic [3:0] CYC_RMW_REG = 4'h3;
	localparam logic [3:0] CYC_RMW_MEM = 4'h5;
	localparam logic [3:0] CYC_RMW_IX1 = 4'h6;
	localparam logic [3:0] CYC_LD_IMM = 4'h2;
	localparam logic [3:0] CYC_LD_DIR = 4'h3;
	localparam logic [3:0] CYC_LD_EXT = 4'h4;
	localparam logic [3:0] CYC_LD_IX0 = 4'h3;
	localparam logic [3:0] CYC_LD_IX1 = 4'h4;
	localparam logic [3:0] CYC_LD_IX2 = 4'h5;

	// ----------------------------------------
	// Register layout and reset values
	// ----------------------------------------
	localparam logic [7:0] SP_RESET = 8'h7F;
	localparam int CC_H = 4;
	localparam int CC_I = 3;
	localparam int CC_N = 2;
	localparam int CC_Z = 1;
	localparam int CC_C = 0;
	localparam logic [4:0] CC_RESET = 5'h08;
	localparam logic [2:0] CC_FILL = 3'h7;
	localparam logic [2:0] RTI_LAST = 3'h4;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// ----------------------------------------
	// APB register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_IDX = 8'h08;
	localparam logic [7:0] OFS_SP = 8'h0C;
	localparam logic [7:0] OFS_CC = 8'h10;
	localparam logic [7:0] OFS_PC = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {S_HALT, S_OPC, S_B1, S_B2, S_MEM, S_WR, S_PULL, S_PAD} cslr_state_t;
	typedef struct packed {logic re; logic we; logic [15:0] addr; logic [7:0] wdata;} cslr_mem_req_t;
	typedef struct packed {logic [7:0] res; logic [4:0] cc;} cslr_alu_t;

endpackage

// ### logic/cslr_core.sv
// Execution core for index load, shifts, rotates, multiply, negate, OR, stack reload, return.
// Assumes memory answers mem_rdata for mem_req.addr within the same cycle; APB on mclk.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps

// Notes on behaviour
// - index load sets N, Z; H, I, C kept
// - index load six modes, cycles 2..5
// - shift left, zero in, old bit7 to carry
// - shift right, zero in, N cleared
// - negate is two's complement, sets N, Z
// - negate carry set when operand nonzero
// - no-operation two cycles, only PC moves
// - OR memory into accumulator, sets N, Z
// - rotate left through carry
// - rotate right through carry
// - modify ops take 3, 5, 6 cycles
// - stack reload loads 7F, flags kept
// - return pulls CC, A, X, PROGRAM_COUNTER_HIGH, PROGRAM_COUNTER_LOW, 9 cycles
// - mask bit follows stacked copy
// - all flags straight from first pulled byte
// - flag byte layout, top three bits ones
module cslr_core #(
	parameter logic [15:0] RESET_PC = cslr_pkg::PC_RESET
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Memory port
	output cslr_pkg::cslr_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	cslr_pkg::cslr_state_t state_q, state_d;
	cslr_pkg::cslr_mem_req_t req_q, req_d;
	logic [7:0] op_q, op_d, a_q, a_d, x_q, x_d, sp_q, sp_d, hi_q, hi_d;
	logic [4:0] cc_q, cc_d;
	logic [15:0] pc_q, pc_d, ea_q, ea_d;
	logic [3:0] cyc_q, cyc_d, tot_q, tot_d;
	logic [2:0] pull_q, pull_d;
	logic illegal_q, illegal_d, run_q, run_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [7:0] cur_op;
	logic [3:0] op_hi, op_lo;
	logic is_rmw, is_ld, fin, apb_done, ill_clr;
	cslr_pkg::cslr_alu_t mem_alu;

	// Operation on one byte; N and Z always follow the result
	function automatic cslr_pkg::cslr_alu_t alu_f(input logic [3:0] fn, input logic [7:0] v,
		input logic [7:0] acc, input logic [4:0] cc);
		cslr_pkg::cslr_alu_t r;
		r.res = v;
		r.cc = cc;
		case (fn)
			cslr_pkg::LO_NEG:
			begin
				r.res = 8'h00 - v;
				r.cc[cslr_pkg::CC_C] = |v;
			end
			cslr_pkg::LO_LSR:
			begin
				r.res = {1'b0, v[7:1]};
				r.cc[cslr_pkg::CC_C] = v[0];
			end
			cslr_pkg::LO_ROR:
			begin
				r.res = {cc[cslr_pkg::CC_C], v[7:1]};
				r.cc[cslr_pkg::CC_C] = v[0];
			end
			cslr_pkg::LO_LSL:
			begin
				r.res = {v[6:0], 1'b0};
				r.cc[cslr_pkg::CC_C] = v[7];
			end
			cslr_pkg::LO_ROL:
			begin
				r.res = {v[6:0], cc[cslr_pkg::CC_C]};
				r.cc[cslr_pkg::CC_C] = v[7];
			end
			cslr_pkg::LO_ORA: r.res = acc | v;
			default: r.res = v;
		endcase
		r.cc[cslr_pkg::CC_N] = r.res[7];
		r.cc[cslr_pkg::CC_Z] = (r.res == 8'h00);
		return r;
	endfunction

	// Read request at a given address
	function automatic cslr_pkg::cslr_mem_req_t rd_f(input logic [15:0] addr);
		rd_f = '{re: 1'b1, we: 1'b0, addr: addr, wdata: 8'h00};
	endfunction

	// Opcode is live on the bus during decode, stored afterwards
	assign cur_op = (state_q == cslr_pkg::S_OPC) ? mem_rdata : op_q;
	assign op_hi = cur_op[7:4];
	assign op_lo = cur_op[3:0];
	assign is_rmw = op_lo inside {cslr_pkg::LO_NEG, cslr_pkg::LO_LSR, cslr_pkg::LO_ROR,
		cslr_pkg::LO_LSL, cslr_pkg::LO_ROL} &&
		op_hi inside {[cslr_pkg::HI_RMW_DIR:cslr_pkg::HI_RMW_IX0]};
	assign is_ld = (op_lo == cslr_pkg::LO_ORA || op_lo == cslr_pkg::LO_LDX) &&
		op_hi >= cslr_pkg::HI_IMM;
	assign mem_alu = alu_f(op_lo, mem_rdata, a_q, cc_q);

	// ----------------------------------------
	// Instruction sequencer
	// ----------------------------------------
	// One memory access per cycle; short paths pad to the full cycle count
	always_comb
	begin
		state_d = state_q;
		req_d = '0;
		op_d = op_q;
		a_d = a_q;
		x_d = x_q;
		sp_d = sp_q;
		cc_d = cc_q;
		pc_d = pc_q;
		hi_d = hi_q;
		ea_d = ea_q;
		tot_d = tot_q;
		pull_d = pull_q;
		cyc_d = cyc_q + 4'h1;
		fin = 1'b0;
		// Hardware set wins over a software clear in the same cycle
		illegal_d = illegal_q & ~ill_clr;
		unique case (state_q)
			cslr_pkg::S_HALT: fin = 1'b1;
			cslr_pkg::S_OPC:
			begin
				op_d = mem_rdata;
				pc_d = pc_q + 16'h0001;
				tot_d = cslr_pkg::CYC_INH;
				fin = 1'b1;
				if (mem_rdata == cslr_pkg::OPC_MUL)
				begin
					{x_d, a_d} = x_q * a_q;
					cc_d[cslr_pkg::CC_H] = 1'b0;
					cc_d[cslr_pkg::CC_C] = 1'b0;
					tot_d = cslr_pkg::CYC_MUL;
				end
				else if (mem_rdata == cslr_pkg::OPC_RSP)
					sp_d = cslr_pkg::SP_RESET;
				else if (mem_rdata == cslr_pkg::OPC_RTI)
				begin
					tot_d = cslr_pkg::CYC_RTI;
					sp_d = sp_q + 8'h01;
					req_d = rd_f({8'h00, sp_d});
					pull_d = 3'h0;
					fin = 1'b0;
					state_d = cslr_pkg::S_PULL;
				end
				else if (is_rmw)
				begin
					tot_d = (op_hi == cslr_pkg::HI_RMW_IX1) ? cslr_pkg::CYC_RMW_IX1 :
						cslr_pkg::CYC_RMW_MEM;
					if (op_hi == cslr_pkg::HI_RMW_ACC)
					begin
						{a_d, cc_d} = alu_f(op_lo, a_q, a_q, cc_q);
						tot_d = cslr_pkg::CYC_RMW_REG;
					end
					else if (op_hi == cslr_pkg::HI_RMW_IDX)
					begin
						{x_d, cc_d} = alu_f(op_lo, x_q, a_q, cc_q);
						tot_d = cslr_pkg::CYC_RMW_REG;
					end
					else if (op_hi == cslr_pkg::HI_RMW_IX0)
					begin
						ea_d = {8'h00, x_q};
						req_d = rd_f(ea_d);
						fin = 1'b0;
						state_d = cslr_pkg::S_MEM;
					end
					else
					begin
						req_d = rd_f(pc_d);
						fin = 1'b0;
						state_d = cslr_pkg::S_B1;
					end
				end
				else if (is_ld)
				begin
					unique case (op_hi)
						cslr_pkg::HI_IMM: tot_d = cslr_pkg::CYC_LD_IMM;
						cslr_pkg::HI_DIR: tot_d = cslr_pkg::CYC_LD_DIR;
						cslr_pkg::HI_EXT: tot_d = cslr_pkg::CYC_LD_EXT;
						cslr_pkg::HI_IX2: tot_d = cslr_pkg::CYC_LD_IX2;
						cslr_pkg::HI_IX1: tot_d = cslr_pkg::CYC_LD_IX1;
						default: tot_d = cslr_pkg::CYC_LD_IX0;
					endcase
					fin = 1'b0;
					if (op_hi == cslr_pkg::HI_IX0)
					begin
						ea_d = {8'h00, x_q};
						req_d = rd_f(ea_d);
						state_d = cslr_pkg::S_MEM;
					end
					else
					begin
						req_d = rd_f(pc_d);
						state_d = cslr_pkg::S_B1;
					end
				end
				else if (mem_rdata != cslr_pkg::OPC_NOP)
					// Opcodes outside this slice run as a two-cycle no-operation
					illegal_d = 1'b1;
			end
			cslr_pkg::S_B1:
			begin
				pc_d = pc_q + 16'h0001;
				if (op_hi == cslr_pkg::HI_IMM)
				begin
					fin = 1'b1;
					if (op_lo == cslr_pkg::LO_LDX)
						x_d = mem_alu.res;
					else
						a_d = mem_alu.res;
					cc_d = mem_alu.cc;
				end
				else if (op_hi == cslr_pkg::HI_EXT || op_hi == cslr_pkg::HI_IX2)
				begin
					hi_d = mem_rdata;
					req_d = rd_f(pc_d);
					state_d = cslr_pkg::S_B2;
				end
				else
				begin
					// Direct or one-byte offset
					ea_d = {8'h00, mem_rdata};
					if (op_hi == cslr_pkg::HI_IX1 || op_hi == cslr_pkg::HI_RMW_IX1)
						ea_d = ea_d + {8'h00, x_q};
					req_d = rd_f(ea_d);
					state_d = cslr_pkg::S_MEM;
				end
			end
			cslr_pkg::S_B2:
			begin
				pc_d = pc_q + 16'h0001;
				ea_d = {hi_q, mem_rdata};
				if (op_hi == cslr_pkg::HI_IX2)
					ea_d = ea_d + {8'h00, x_q};
				req_d = rd_f(ea_d);
				state_d = cslr_pkg::S_MEM;
			end
			cslr_pkg::S_MEM:
			begin
				cc_d = mem_alu.cc;
				if (is_rmw)
				begin
					req_d = '{re: 1'b0, we: 1'b1, addr: ea_q, wdata: mem_alu.res};
					state_d = cslr_pkg::S_WR;
				end
				else
				begin
					fin = 1'b1;
					if (op_lo == cslr_pkg::LO_LDX)
						x_d = mem_alu.res;
					else
						a_d = mem_alu.res;
				end
			end
			cslr_pkg::S_WR: fin = 1'b1;
			cslr_pkg::S_PULL:
			begin
				unique case (pull_q)
					3'h0: cc_d = mem_rdata[4:0];
					3'h1: a_d = mem_rdata;
					3'h2: x_d = mem_rdata;
					3'h3: pc_d[15:8] = mem_rdata;
					default: pc_d[7:0] = mem_rdata;
				endcase
				if (pull_q == cslr_pkg::RTI_LAST)
					fin = 1'b1;
				else
				begin
					sp_d = sp_q + 8'h01;
					req_d = rd_f({8'h00, sp_d});
					pull_d = pull_q + 3'h1;
				end
			end
			cslr_pkg::S_PAD: fin = 1'b1;
		endcase
		// Next fetch only once the instruction has used all its cycles
		if (fin && (state_q == cslr_pkg::S_HALT || cyc_q + 4'h1 >= tot_d))
		begin
			cyc_d = 4'h0;
			req_d = '0;
			state_d = cslr_pkg::S_HALT;
			if (run_q)
			begin
				req_d = rd_f(pc_d);
				state_d = cslr_pkg::S_OPC;
			end
		end
		else if (fin)
			state_d = cslr_pkg::S_PAD;
	end

	// Sequencer registers
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= cslr_pkg::S_HALT;
			req_q <= '0;
			op_q <= 8'h00;
			a_q <= 8'h00;
			x_q <= 8'h00;
			sp_q <= cslr_pkg::SP_RESET;
			cc_q <= cslr_pkg::CC_RESET;
			pc_q <= RESET_PC;
			hi_q <= 8'h00;
			ea_q <= 16'h0000;
			tot_q <= cslr_pkg::CYC_INH;
			cyc_q <= 4'h0;
			pull_q <= 3'h0;
			illegal_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			req_q <= req_d;
			op_q <= op_d;
			a_q <= a_d;
			x_q <= x_d;
			sp_q <= sp_d;
			cc_q <= cc_d;
			pc_q <= pc_d;
			hi_q <= hi_d;
			ea_q <= ea_d;
			tot_q <= tot_d;
			cyc_q <= cyc_d;
			pull_q <= pull_d;
			illegal_q <= illegal_d;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// One wait state keeps every answer straight from a flop
	assign apb_done = psel & penable & pready_q;
	assign ill_clr = apb_done & pwrite & (paddr == cslr_pkg::OFS_STAT) & pwdata[1];
	always_comb
	begin
		run_d = run_q;
		pready_d = psel & penable & ~pready_q;
		prdata_d = 32'h00000000;
		pslverr_d = 1'b0;
		if (apb_done && pwrite && paddr == cslr_pkg::OFS_CTRL)
			run_d = pwdata[0];
		if (pready_d)
		begin
			unique case (paddr)
				cslr_pkg::OFS_CTRL: prdata_d = {31'h0, run_q};
				cslr_pkg::OFS_ACC: prdata_d = {24'h0, a_q};
				cslr_pkg::OFS_IDX: prdata_d = {24'h0, x_q};
				cslr_pkg::OFS_SP: prdata_d = {24'h0, sp_q};
				// flag byte with ones on top
				cslr_pkg::OFS_CC: prdata_d = {24'h0, cslr_pkg::CC_FILL, cc_q};
				cslr_pkg::OFS_PC: prdata_d = {16'h0, pc_q};
				cslr_pkg::OFS_STAT: prdata_d = {30'h0, illegal_q, state_q == cslr_pkg::S_HALT};
				default: pslverr_d = 1'b1;
			endcase
		end
	end

	// APB registers
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			run_q <= 1'b1;
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			run_q <= run_d;
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign mem_req = req_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	chk_ldx_load: assert property ((state_q == cslr_pkg::S_B1 &&
		op_q == {cslr_pkg::HI_IMM, cslr_pkg::LO_LDX}) |=> x_q == $past(mem_rdata) &&
		cc_q[cslr_pkg::CC_Z] == (x_q == 8'h00) &&
		cc_q[cslr_pkg::CC_C] == $past(cc_q[cslr_pkg::CC_C]) &&
		cc_q[cslr_pkg::CC_I] == $past(cc_q[cslr_pkg::CC_I]))
		else $error("index load value or flags wrong");
	chk_ldx_ext_len: assert property ((state_q == cslr_pkg::S_OPC &&
		mem_rdata == {cslr_pkg::HI_EXT, cslr_pkg::LO_LDX}) |=>
		(state_q != cslr_pkg::S_OPC)[*3] ##1 state_q inside {cslr_pkg::S_OPC, cslr_pkg::S_HALT})
		else $error("extended index load not four cycles");
	chk_lsl_acc: assert property ((state_q == cslr_pkg::S_OPC &&
		mem_rdata == {cslr_pkg::HI_RMW_ACC, cslr_pkg::LO_LSL}) |=>
		a_q == {$past(a_q[6:0]), 1'b0} && cc_q[cslr_pkg::CC_C] == $past(a_q[7]))
		else $error("shift left wrong");
	chk_lsr_acc: assert property ((state_q == cslr_pkg::S_OPC &&
		mem_rdata == {cslr_pkg::HI_RMW_ACC, cslr_pkg::LO_LSR}) |=>
		a_q == {1'b0, $past(a_q[7:1])} && !cc_q[cslr_pkg::CC_N] &&
		cc_q[cslr_pkg::CC_C] == $past(a_q[0]))
		else $error("shift right wrong");
	chk_mul_product: assert property ((state_q == cslr_pkg::S_OPC &&
		mem_rdata == cslr_pkg::OPC_MUL) |=> {x_q, a_q} == $past(x_q) * $past(a_q) &&
		!cc_q[cslr_pkg::CC_H] && !cc_q[cslr_pkg::CC_C])
		else $error("multiply wrong");
	chk_neg_acc: assert property ((state_q == cslr_pkg::S_OPC &&
		mem_rdata == {cslr_pkg::HI_RMW_ACC, cslr_pkg::LO_NEG}) |=> a_q == 8'h00 - $past(a_q) &&
		cc_q[cslr_pkg::CC_C] == ($past(a_q) != 8'h00))
		else $error("negate wrong");
	chk_nop_quiet: assert property ((state_q == cslr_pkg::S_OPC &&
		mem_rdata == cslr_pkg::OPC_NOP) |=> $stable({a_q, x_q, sp_q, cc_q}) &&
		pc_q == $past(pc_q) + 16'h0001 ##1 state_q inside {cslr_pkg::S_OPC, cslr_pkg::S_HALT})
		else $error("no-operation disturbed state");
	chk_rmw_ix1_len: assert property ((state_q == cslr_pkg::S_OPC && is_rmw &&
		op_hi == cslr_pkg::HI_RMW_IX1) |-> ##6 state_q inside {cslr_pkg::S_OPC, cslr_pkg::S_HALT})
		else $error("one-byte offset modify not six cycles");
	chk_rsp_load: assert property ((state_q == cslr_pkg::S_OPC &&
		mem_rdata == cslr_pkg::OPC_RSP) |=> sp_q == cslr_pkg::SP_RESET && $stable(cc_q))
		else $error("stack reload wrong");
	chk_rti_length: assert property ((state_q == cslr_pkg::S_OPC &&
		mem_rdata == cslr_pkg::OPC_RTI) |-> ##9 state_q inside {cslr_pkg::S_OPC, cslr_pkg::S_HALT})
		else $error("return not nine cycles");
	chk_rti_flags: assert property ((state_q == cslr_pkg::S_PULL &&
		pull_q == 3'h0) |=> cc_q == $past(mem_rdata[4:0]))
		else $error("return flags not from stack");
	chk_rmw_back: assert property ((state_q == cslr_pkg::S_MEM && is_rmw) |=>
		req_q.we && req_q.addr == $past(ea_q))
		else $error("write-back address differs");

	cov_rti: cover property (state_q == cslr_pkg::S_PULL && pull_q == cslr_pkg::RTI_LAST);
	cov_rmw_write: cover property (state_q == cslr_pkg::S_WR);
	cov_mul: cover property (state_q == cslr_pkg::S_OPC && mem_rdata == cslr_pkg::OPC_MUL);
	cov_halt: cover property (state_q == cslr_pkg::S_HALT ##1 state_q == cslr_pkg::S_OPC);

endmodule

// ### verification/cslr_mem_model.sv
// Byte-wide memory partner for the execution core, with a log of read timing.
// Assumes one access per cycle, read answered in the same cycle, write at the edge.
`timescale 1ns/100ps
module cslr_mem_model (
	// Clock
	input wire logic mclk,
	// Core request and read data
	input wire cslr_pkg::cslr_mem_req_t mem_req,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q = 8'h00;
	int cyc = 0;
	int first_rd [0:255];

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Idle bus shows the inverse of the last byte, so stale data never passes
	assign mem_rdata = mem_req.re ? mem[mem_req.addr] : ~last_q;

	// ----------------------------------------
	// Write, cycle count and first-read log
	// ----------------------------------------
	// Log only the first read, so an opcode fetch marks its instruction start
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (mem_req.re)
		begin
			last_q <= mem[mem_req.addr];
			if (mem_req.addr[15:8] == 8'h00 && first_rd[mem_req.addr[7:0]] < 0)
				first_rd[mem_req.addr[7:0]] <= cyc;
		end
		if (mem_req.we)
			mem[mem_req.addr] <= mem_req.wdata;
	end

	// Empty log at start
	initial
	begin
		for (int i = 0; i < 256; i++)
			first_rd[i] = -1;
	end
endmodule

// ### verification/tb_top.sv
// Testbench: runs a fixed program from memory, then checks state over APB and memory.
// Assumes the core starts fetching at address 0000 right after reset.
`timescale 1ns/100ps
module tb_top;
	// ----------------------------------------
	// Signals and tables
	// ----------------------------------------
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] mem_rdata;
	cslr_pkg::cslr_mem_req_t mem_req;
	int miscompares = 0;
	int checks = 0;
	logic [31:0] rd;
	logic er;
	// Program body placed from 0010, after the return at 0000
	localparam logic [7:0] PROG [0:39] = '{8'hBE, 8'h90, 8'hCE, 8'h00, 8'h91, 8'hFE, 8'hEE,
		8'h90, 8'hDE, 8'h00, 8'h13, 8'h9D, 8'hAA, 8'h81, 8'h48, 8'h49, 8'h46, 8'h44, 8'h40,
		8'h42, 8'h38, 8'h97, 8'h34, 8'h98, 8'h39, 8'h99, 8'h36, 8'h9A, 8'h30, 8'h9B, 8'h30,
		8'h9A, 8'h68, 8'h20, 8'hAE, 8'h9C, 8'h78, 8'hBA, 8'h9E, 8'h9C};
	// Instruction start addresses and their cycle counts
	localparam logic [7:0] PCS [0:25] = '{8'h00, 8'h10, 8'h12, 8'h15, 8'h16, 8'h18, 8'h1B,
		8'h1C, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26, 8'h28, 8'h2A, 8'h2C,
		8'h2E, 8'h30, 8'h32, 8'h34, 8'h35, 8'h37, 8'h38};
	localparam int CYC [0:24] = '{9, 3, 4, 3, 4, 5, 2, 2, 3, 3, 3, 3, 3, 11, 5, 5, 5, 5, 5,
		5, 6, 2, 5, 3, 2};
	// Stack frame and operands {address, byte}; expected bytes after the run
	localparam logic [15:0] DIN [0:17] = '{16'h80F5, 16'h8100, 16'h8203, 16'h8300,
		16'h8410, 16'h90C5, 16'h9192, 16'h9204, 16'h9483, 16'h967E, 16'h9781, 16'h9801,
		16'h9940, 16'h9A01, 16'h9B80, 16'h9C03, 16'h9DC0, 16'h9E04};
	localparam logic [15:0] DOUT [0:6] = '{16'h9702, 16'h9800, 16'h9981, 16'h9A00,
		16'h9B80, 16'h9C06, 16'h9D80};

	// Clock
	always #25 mclk = ~mclk;

	// ----------------------------------------
	// Design and memory partner
	// ----------------------------------------
	cslr_core u_dut (.mclk(mclk), .rstn(rstn), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	cslr_mem_model u_mem (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Value compare
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			check(32'h0, 32'h1, "no pready");
	endtask

	// Verdict
	task automatic close_out;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		for (int i = 0; i < 256; i++)
			u_mem.mem[i] = 8'h00;
		u_mem.mem[0] = cslr_pkg::OPC_RTI;
		for (int i = 0; i < 40; i++)
			u_mem.mem[16 + i] = PROG[i];
		for (int i = 0; i < 18; i++)
			u_mem.mem[DIN[i][15:8]] = DIN[i][7:0];
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		// Program ends near cycle 106; later opcodes are idle fillers
		repeat (130) @(posedge mclk);
		apb(1'b1, cslr_pkg::OFS_CTRL, 32'h0);
		// The write hands back the control word, so poll status afresh
		apb(1'b0, cslr_pkg::OFS_STAT, 32'h0);
		for (int i = 0; i < 10 && rd[0] !== 1'b1; i++)
			apb(1'b0, cslr_pkg::OFS_STAT, 32'h0);
		check(rd, 32'h3, "status halted");
		apb(1'b1, cslr_pkg::OFS_STAT, 32'h2);
		apb(1'b0, cslr_pkg::OFS_STAT, 32'h0);
		check(rd, 32'h1, "status cleared");
		// Register results
		apb(1'b0, cslr_pkg::OFS_ACC, 32'h0);
		check(rd, 32'h86, "acc");
		apb(1'b0, cslr_pkg::OFS_IDX, 32'h0);
		check(rd, 32'h9C, "index");
		apb(1'b0, cslr_pkg::OFS_SP, 32'h0);
		check(rd, 32'h7F, "stack pointer");
		apb(1'b0, cslr_pkg::OFS_CC, 32'h0);
		check(rd, 32'hE4, "flags");
		apb(1'b0, 8'h40, 32'h0);
		check({31'h0, er}, 32'h1, "unmapped error");
		check(rd, 32'h0, "unmapped data");
		// Memory results of the modify instructions
		for (int i = 0; i < 7; i++)
			check({24'h0, u_mem.mem[DOUT[i][15:8]]}, {24'h0, DOUT[i][7:0]},
				"mem");
		// Instruction lengths from opcode fetch times
		for (int i = 0; i < 25; i++)
			check(32'(u_mem.first_rd[PCS[i + 1]] - u_mem.first_rd[PCS[i]]), 32'(CYC[i]),
				"cycles");
		// Stack pulls in order from the incremented pointer
		for (int k = 0; k < 5; k++)
			check(32'(u_mem.first_rd[8'h80 + k] - u_mem.first_rd[0]), 32'(k + 1), "pull");
		close_out;
	end

	// Watchdog
	initial
	begin
		#(50 * 5000);
		check(32'h0, 32'h1, "timeout");
		close_out;
	end
endmodule
